// ==== rtl/tsense_consts.svh ====
// Purpose: constants of the sensor serial command port
// Assumes: core clock of 10 MHz
// Notes: included by the port top module and the testbench only
`ifndef TSENSE_CONSTS_SVH
`define TSENSE_CONSTS_SVH

`define CMD_RESET 8'h1e
`define CMD_CONV 8'h48
`define CMD_RDRES 8'h00
`define PROM_TAG 4'ha
`define I2C_ADDR_HI 6'h3b
`define CLK_PERIOD_NS 100
`define CONV_TIME_US 8220
`define CONV_CYC (`CONV_TIME_US * 1000 / `CLK_PERIOD_NS)
`define RES_BYTES 2'd3
`define PROM_BYTES 2'd2
`define FIFO_DEPTH 8
`define IDLE_BYTE 8'hff
`define BIT_LAST 3'h7
`define PROM_WORDS {16'h0000, 16'h6f1e, 16'h615e, 16'h8cb0, \
	16'h8017, 16'h9f4d, 16'h0005}
`define SN_LOW 8'h96

`endif

// ==== rtl/tsense_pkg.sv ====
// Purpose: types shared by the sensor serial command port
// Assumes: nothing beyond the constants header
// Notes: pin bundle order is fixed, the synchroniser keeps it
package tsense_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [16:0] conv_cnt_t;
	typedef logic [15:0] word_t;
	typedef struct packed {
		logic protocol_select_pin;
		logic chip_select_or_address_pin;
		logic sclk;
		logic sdi_sda;
	} link_pins_t;
	typedef enum logic [2:0] {
		I_IDLE, I_ADDR, I_AACK, I_CMD, I_CACK, I_TX, I_MACK, I_SKIP
	} i2c_state_t;
endpackage

// ==== rtl/pin_sync.sv ====
// Purpose: two-stage synchroniser for the link pins
// Assumes: pins are asynchronous to clk
// Notes: only the second stage leaves the module
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					meta_q[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta_q[i] <= d[i];
					q[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ==== rtl/byte_fifo.sv ====
// Purpose: small synchronous fifo for outgoing data bytes
// Assumes: single clock
// Notes: clr empties it at once and beats a same-cycle push
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q, rd_q;
	logic push, pop;

	assign in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem[rd_q[AW-1:0]];
	assign push = in_valid && in_ready && !clr;
	assign pop = out_valid && out_ready && !clr;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (clr) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW + 1)'(push);
			rd_q <= rd_q + (AW + 1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ==== rtl/tsense_port.sv ====
// Purpose: SPI / I2C slave and command engine of the temperature sensor
// Assumes: link pins toggle far slower than clk (>= 4 clk per level)
// Notes: the analog converter sits outside; adc_run gates it
`timescale 1ns/1ps
`default_nettype none
`include "tsense_consts.svh"
module tsense_port #(
	parameter int CONV_CYCLES = `CONV_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire tsense_pkg::link_pins_t link_pins,
	input wire logic [23:0] adc_value,
	output logic sdo,
	output logic sda_out,
	output logic sda_oe,
	output logic adc_run
);
	import tsense_pkg::*;

	////////////////////////////////////////////////////////////////////
	// pin sampling and edges
	link_pins_t pins_s;
	logic scl_p_q, sda_p_q;
	logic i2c_mode, spi_sel, scl_rise, scl_fall, i2c_start, i2c_stop;
	logic [6:0] dev_addr;

	pin_sync #(.W(4)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d(link_pins),
		.q(pins_s)
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_p_q <= 1'b0;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= pins_s.sclk;
			sda_p_q <= pins_s.sdi_sda;
		end
	end

	assign i2c_mode = pins_s.protocol_select_pin;
	assign spi_sel = !i2c_mode && !pins_s.chip_select_or_address_pin;
	assign scl_rise = pins_s.sclk && !scl_p_q;
	assign scl_fall = !pins_s.sclk && scl_p_q;
	assign i2c_start = i2c_mode && pins_s.sclk && scl_p_q && sda_p_q &&
		!pins_s.sdi_sda;
	assign i2c_stop = i2c_mode && pins_s.sclk && scl_p_q && !sda_p_q &&
		pins_s.sdi_sda;
	// select pin high picks the even address
	assign dev_addr = {`I2C_ADDR_HI, !pins_s.chip_select_or_address_pin};

	////////////////////////////////////////////////////////////////////
	// shared receive shifter, both links sample on the rising edge
	i2c_state_t st_q;
	byte_t rx_q, byte_val;
	logic [2:0] bit_q;
	logic count_en, byte_done;

	assign count_en = !i2c_start && (spi_sel || (i2c_mode &&
		(st_q == I_ADDR || st_q == I_CMD || st_q == I_TX)));
	assign byte_done = count_en && scl_rise && bit_q == `BIT_LAST;
	assign byte_val = {rx_q[6:0], pins_s.sdi_sda};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_q <= '0;
		end else if (scl_rise) begin
			rx_q <= byte_val;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_q <= '0;
		end else if (!count_en) begin
			bit_q <= '0;
		end else if (scl_rise) begin
			bit_q <= bit_q + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// spi framing
	logic data_ph_q, rose_q, spi_cmd, spi_fall;

	assign spi_cmd = !i2c_mode && byte_done && !data_ph_q;
	// mode 3 opens with a falling edge; rose_q keeps it from shifting
	assign spi_fall = spi_sel && data_ph_q && rose_q && scl_fall;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_ph_q <= 1'b0;
			rose_q <= 1'b0;
		end else if (!spi_sel) begin
			data_ph_q <= 1'b0;
			rose_q <= 1'b0;
		end else begin
			data_ph_q <= data_ph_q || spi_cmd;
			rose_q <= rose_q || scl_rise;
		end
	end

	////////////////////////////////////////////////////////////////////
	// i2c slave state machine
	logic rw_q, ack_on_q, ld_q, i2c_cmd_ok, aack_rel, tx_fall;

	assign i2c_cmd_ok = st_q == I_CMD && byte_done &&
		(!adc_run || byte_val == `CMD_RESET);
	assign aack_rel = st_q == I_AACK && scl_fall && ack_on_q;
	assign tx_fall = st_q == I_TX && scl_fall;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= I_IDLE;
		end else if (!i2c_mode || i2c_stop) begin
			st_q <= I_IDLE;
		end else if (i2c_start) begin
			st_q <= I_ADDR;
		end else begin
			case (st_q)
				I_ADDR: begin
					// a read is not acknowledged while a conversion is running
					if (byte_done) begin
						st_q <= (byte_val[7:1] == dev_addr &&
							!(byte_val[0] && adc_run)) ? I_AACK : I_SKIP;
					end
				end
				I_AACK: begin
					if (aack_rel) begin
						st_q <= rw_q ? I_TX : I_CMD;
					end
				end
				I_CMD: begin
					if (byte_done) begin
						st_q <= i2c_cmd_ok ? I_CACK : I_SKIP;
					end
				end
				I_CACK: begin
					if (scl_fall && ack_on_q) begin
						st_q <= I_SKIP;
					end
				end
				I_TX: begin
					if (byte_done) begin
						st_q <= I_MACK;
					end
				end
				I_MACK: begin
					if (scl_rise) begin
						st_q <= pins_s.sdi_sda ? I_SKIP : I_TX;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rw_q <= 1'b0;
			ack_on_q <= 1'b0;
			ld_q <= 1'b0;
		end else begin
			if (st_q == I_ADDR && byte_done) begin
				rw_q <= byte_val[0];
			end
			if (st_q == I_AACK || st_q == I_CACK) begin
				ack_on_q <= ack_on_q ^ scl_fall;
			end else begin
				ack_on_q <= 1'b0;
			end
			if (st_q == I_MACK && scl_rise && !pins_s.sdi_sda) begin
				ld_q <= 1'b1;
			end else if (tx_fall) begin
				ld_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// command capture, one code set for both links
	byte_t cmd_q;
	logic cmd_stb_q, is_reset, is_conv, is_rdres, is_prom;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_q <= '0;
			cmd_stb_q <= 1'b0;
		end else begin
			cmd_stb_q <= spi_cmd || i2c_cmd_ok;
			if (spi_cmd || i2c_cmd_ok) begin
				cmd_q <= byte_val;
			end
		end
	end

	assign is_reset = cmd_stb_q && cmd_q == `CMD_RESET;
	assign is_conv = cmd_stb_q && cmd_q == `CMD_CONV;
	assign is_rdres = cmd_stb_q && cmd_q == `CMD_RDRES;
	assign is_prom = cmd_stb_q && cmd_q[7:4] == `PROM_TAG && !cmd_q[0];

	////////////////////////////////////////////////////////////////////
	// conversion timing and result
	conv_cnt_t conv_cnt_q;
	logic [23:0] res_q;
	logic valid_q, conv_done;

	assign conv_done = adc_run && conv_cnt_q == conv_cnt_t'(1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			conv_cnt_q <= '0;
			adc_run <= 1'b0;
		end else if (is_reset) begin
			conv_cnt_q <= '0;
			adc_run <= 1'b0;
		end else if (is_conv && !adc_run) begin
			conv_cnt_q <= conv_cnt_t'(CONV_CYCLES);
			adc_run <= 1'b1;
		end else if (adc_run) begin
			conv_cnt_q <= conv_cnt_q - conv_cnt_t'(1);
			adc_run <= !conv_done;
		end
	end

	// a completion in the clearing cycle still leaves a fresh result
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			res_q <= '0;
			valid_q <= 1'b0;
		end else begin
			if (conv_done) begin
				res_q <= adc_value;
			end
			if (conv_done) begin
				valid_q <= 1'b1;
			end else if (is_rdres || is_reset) begin
				valid_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// prom contents, checksum folded in at elaboration
	localparam logic [111:0] PROM_LO = `PROM_WORDS;

	function automatic byte_t prom_csum();
		byte_t s;
		s = `SN_LOW;
		for (int i = 0; i < 14; i++) begin
			s = s + PROM_LO[i*8 +: 8];
		end
		return byte_t'(8'h00 - s);
	endfunction

	localparam byte_t CSUM = prom_csum();

	function automatic word_t prom_word(input logic [2:0] a);
		word_t w;
		w = {`SN_LOW, CSUM};
		if (a != 3'h7) begin
			w = PROM_LO[(6 - a)*16 +: 16];
		end
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////
	// byte loader into the outgoing fifo
	logic [23:0] ld_data_q;
	logic [1:0] ld_cnt_q;
	logic f_in_ready, f_out_valid, f_pop;
	byte_t f_out;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ld_data_q <= '0;
			ld_cnt_q <= '0;
		end else if (cmd_stb_q) begin
			if (is_rdres) begin
				ld_data_q <= valid_q ? res_q : '0;
				ld_cnt_q <= `RES_BYTES;
			end else if (is_prom) begin
				ld_data_q <= {prom_word(cmd_q[3:1]), 8'h00};
				ld_cnt_q <= `PROM_BYTES;
			end else begin
				ld_cnt_q <= '0;
			end
		end else if (ld_cnt_q != 2'd0 && f_in_ready) begin
			ld_data_q <= {ld_data_q[15:0], 8'h00};
			ld_cnt_q <= ld_cnt_q - 2'd1;
		end
	end

	// any new command drops bytes the master never clocked out
	byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.clr(cmd_stb_q),
		.in_valid(ld_cnt_q != 2'd0),
		.in_ready(f_in_ready),
		.in_data(ld_data_q[23:16]),
		.out_valid(f_out_valid),
		.out_ready(f_pop),
		.out_data(f_out)
	);

	////////////////////////////////////////////////////////////////////
	// transmit shifter, both links change data on the falling edge
	byte_t tx_q, head;
	logic tx_load, tx_shift, out_bit_d, out_bit_q;

	assign tx_load = (spi_fall && bit_q == 3'h0) || (tx_fall && ld_q) ||
		(aack_rel && rw_q);
	assign tx_shift = (spi_fall && bit_q != 3'h0) || (tx_fall && !ld_q);
	assign f_pop = tx_load;
	// an empty fifo sends ones rather than stale data
	assign head = f_out_valid ? f_out : `IDLE_BYTE;
	assign out_bit_d = tx_load ? head[7] : (tx_shift ? tx_q[7] : out_bit_q);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_q <= `IDLE_BYTE;
			out_bit_q <= 1'b1;
		end else begin
			out_bit_q <= out_bit_d;
			if (tx_load) begin
				tx_q <= {head[6:0], 1'b1};
			end else if (tx_shift) begin
				tx_q <= {tx_q[6:0], 1'b1};
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin drivers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sdo <= 1'b1;
		end else if (adc_run) begin
			sdo <= 1'b0;
		end else if (spi_sel && data_ph_q) begin
			sdo <= out_bit_d;
		end else begin
			sdo <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end else if (!i2c_mode || i2c_start || i2c_stop) begin
			sda_oe <= 1'b0;
		end else if (scl_fall) begin
			if (tx_load || tx_shift) begin
				sda_oe <= !out_bit_d;
			end else if ((st_q == I_AACK || st_q == I_CACK) && !ack_on_q) begin
				sda_oe <= 1'b1;
			end else begin
				sda_oe <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_prom_load;
		ld_cnt_q == 2'd2 ##[1:8] ld_cnt_q == 2'd1 ##[1:8] ld_cnt_q == 2'd0;
	endsequence

	a_busy_sdo_low: assert property (adc_run |=> !sdo)
		else $error("sdo not low while converting");
	a_done_sdo_high: assert property ($fell(adc_run) && !data_ph_q |=> sdo)
		else $error("sdo not high after conversion");
	a_conv_starts: assert property (is_conv && !adc_run |=> adc_run [*8])
		else $error("conversion did not start");
	// a completion in the reset cycle still sets freshness, set wins
	a_reset_clears: assert property (is_reset |=> !adc_run &&
		(!valid_q || $past(conv_done)))
		else $error("reset command left state behind");
	a_i2c_refuse: assert property (st_q == I_CMD && byte_done && adc_run &&
		byte_val != `CMD_RESET |=> !cmd_stb_q && st_q == I_SKIP)
		else $error("command executed while converting");
	a_res_zero: assert property (is_rdres && !valid_q |=> ld_data_q == '0)
		else $error("stale result not zero");
	a_prom_two_bytes: assert property (is_prom |=> s_prom_load)
		else $error("prom word not loaded as two bytes");
	a_addr_nack: assert property (st_q == I_ADDR && byte_done &&
		byte_val[7:1] != dev_addr |=> st_q == I_SKIP)
		else $error("foreign address acknowledged");
	a_cs_ignore: assert property (!i2c_mode && !spi_sel |=> !data_ph_q)
		else $error("link used while deselected");
endmodule
`default_nettype wire

// ==== test/host_master.sv ====
// Purpose: host master model on the sensor link pins, SPI and I2C
// Assumes: hp core cycles per SPI clock level, 4 per I2C level
// Notes: pins move just after clk rise; sda is open drain with pull-up
`timescale 1ns/1ps
`default_nettype none
module host_master (
	input wire logic clk,
	input wire logic sdo,
	input wire logic sda_oe,
	output tsense_pkg::link_pins_t link_pins
);
	import tsense_pkg::*;
	logic proto_q, csa_q, sclk_q, dat_q, sda_w;
	int hp = 4;
	// released sda floats high unless the device pulls it
	assign sda_w = dat_q & ~sda_oe;
	assign link_pins = {proto_q, csa_q, sclk_q, proto_q ? sda_w : dat_q};
	initial begin
		proto_q = 1'b0;
		csa_q = 1'b1;
		sclk_q = 1'b0;
		dat_q = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic set_mode(input logic proto, input logic csa,
		input logic idle);
		proto_q <= proto;
		csa_q <= csa;
		sclk_q <= idle;
		dat_q <= 1'b1;
		w(8);
	endtask
	////////////////////////////////////////////////////////////////////////
	// command byte, then 24 bits read back when get is set
	task automatic spi_frame(input logic sel, input logic m3,
		input byte_t cmd, input logic get, output logic [23:0] rx);
		logic [31:0] tx;
		tx = {cmd, 24'hffffff};
		rx = 24'h0;
		csa_q <= ~sel;
		w(4);
		for (int i = 0; i < (get ? 32 : 8); i++) begin
			sclk_q <= 1'b0;
			dat_q <= tx[31-i];
			w(hp);
			sclk_q <= 1'b1;
			w(hp);
			if (i > 7) rx = {rx[22:0], sdo};
		end
		sclk_q <= m3;
		w(4);
		csa_q <= 1'b1;
		// a released line must not keep showing the last bit
		dat_q <= ~dat_q;
		w(4);
	endtask
	////////////////////////////////////////////////////////////////////////
	// data moves one cycle after the fall, away from scl high
	task automatic i2c_bit(input logic b, output logic r);
		sclk_q <= 1'b0;
		w(1);
		dat_q <= b;
		w(3);
		sclk_q <= 1'b1;
		w(4);
		r = sda_w;
	endtask
	task automatic i2c_start();
		dat_q <= 1'b1;
		sclk_q <= 1'b1;
		w(4);
		dat_q <= 1'b0;
		w(4);
	endtask
	task automatic i2c_stop();
		sclk_q <= 1'b0;
		w(1);
		dat_q <= 1'b0;
		w(3);
		sclk_q <= 1'b1;
		w(4);
		dat_q <= 1'b1;
		w(4);
	endtask
	task automatic i2c_wbyte(input byte_t b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) i2c_bit(b[i], r);
		i2c_bit(1'b1, r);
		ack = ~r;
	endtask
	task automatic i2c_msg(input byte_t a, input byte_t c, output logic a1,
		output logic a2);
		i2c_start();
		i2c_wbyte(a, a1);
		i2c_wbyte(c, a2);
		i2c_stop();
	endtask
	// three bytes, master nacks the last
	task automatic i2c_read(input byte_t a, output logic a1,
		output logic [23:0] rx);
		logic r;
		i2c_start();
		i2c_wbyte(a, a1);
		for (int i = 23; i >= 0; i--) begin
			i2c_bit(1'b1, r);
			rx[i] = r;
			if (i % 8 == 0) i2c_bit(i == 0, r);
		end
		i2c_stop();
	endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: self-checking bench of the sensor serial command port
// Assumes: host_master drives the link pins
// Notes: conversion shortened to CONV cycles to keep the run short
`timescale 1ns/1ps
`default_nettype none
`include "tsense_consts.svh"
module testbench;
	import tsense_pkg::*;
	localparam int CONV = 1000;
	localparam logic [111:0] PW = `PROM_WORDS;
	logic clk, rst_b, sdo, sda_out, sda_oe, adc_run, run_d, a1, a2;
	logic [23:0] adc_value, rx;
	link_pins_t link_pins;
	int busy_cnt, cyc, num_errors, num_checks;
	tsense_port #(.CONV_CYCLES(CONV)) dut (.clk(clk), .rst_b(rst_b),
		.link_pins(link_pins), .adc_value(adc_value), .sdo(sdo),
		.sda_out(sda_out), .sda_oe(sda_oe), .adc_run(adc_run));
	host_master host (.clk(clk), .sdo(sdo), .sda_oe(sda_oe),
		.link_pins(link_pins));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// busy length counted from the device's own run flag
	always @(posedge clk) begin
		run_d <= adc_run;
		if (adc_run === 1'b1) busy_cnt <= (run_d === 1'b1) ? busy_cnt + 1 : 1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	function automatic word_t exp_word(input int k);
		byte_t s;
		s = `SN_LOW;
		for (int i = 0; i < 14; i++) s = s + PW[8*i +: 8];
		if (k < 7) return PW[111 - 16*k -: 16];
		return {`SN_LOW, 8'h00 - s};
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		host.set_mode(1'b0, 1'b1, 1'b0);
		host.spi_frame(1'b1, 1'b0, `CMD_RESET, 1'b0, rx);
		chk({23'h0, sdo}, 24'h1);
		chk({23'h0, adc_run}, 24'h0);
	endtask
	task automatic t_conv_spi();
		int n;
		host.spi_frame(1'b1, 1'b0, `CMD_RDRES, 1'b1, rx);
		chk(rx, 24'h0);
		host.spi_frame(1'b0, 1'b0, `CMD_CONV, 1'b0, rx);
		chk({23'h0, adc_run}, 24'h0);
		host.spi_frame(1'b1, 1'b0, `CMD_CONV, 1'b0, rx);
		chk({22'h0, sdo, adc_run}, 24'h1);
		n = 0;
		while (sdo !== 1'b1 && n < 2 * CONV) begin
			@(posedge clk);
			n++;
		end
		chk({23'h0, adc_run}, 24'h0);
		chk(24'(busy_cnt), 24'(CONV));
		host.spi_frame(1'b1, 1'b0, `CMD_RDRES, 1'b1, rx);
		chk(rx, adc_value);
		host.spi_frame(1'b1, 1'b0, `CMD_RDRES, 1'b1, rx);
		chk(rx, 24'h0);
	endtask
	// mode 3 also runs with a slower link clock
	task automatic t_prom(input logic m3);
		host.hp = m3 ? 6 : 4;
		host.set_mode(1'b0, 1'b1, m3);
		for (int k = 0; k < 8; k++) begin
			host.spi_frame(1'b1, m3, 8'(8'ha0 + 2 * k), 1'b1, rx);
			chk(rx, {exp_word(k), 8'hff});
		end
	endtask
	task automatic t_i2c();
		int n;
		host.set_mode(1'b1, 1'b1, 1'b1);
		host.i2c_msg(8'hee, `CMD_RESET, a1, a2);
		chk({22'h0, a1, a2}, 24'h0);
		host.i2c_msg(8'hec, 8'ha2, a1, a2);
		chk({22'h0, a1, a2}, 24'h3);
		host.i2c_read(8'hed, a1, rx);
		chk(rx, {exp_word(1), 8'hff});
		host.set_mode(1'b1, 1'b0, 1'b1);
		host.i2c_msg(8'hee, `CMD_CONV, a1, a2);
		chk({22'h0, a1, a2}, 24'h3);
		host.i2c_read(8'hef, a1, rx);
		chk({23'h0, a1}, 24'h0);
		host.i2c_msg(8'hee, 8'ha4, a1, a2);
		chk({22'h0, a1, a2}, 24'h2);
		host.i2c_msg(8'hee, `CMD_RESET, a1, a2);
		chk({21'h0, a1, a2, adc_run}, 24'h6);
		adc_value <= 24'h3c5a0f;
		host.i2c_msg(8'hee, `CMD_CONV, a1, a2);
		n = 0;
		a2 = 1'b0;
		while (a2 !== 1'b1 && n < 20) begin
			host.i2c_msg(8'hee, `CMD_RDRES, a1, a2);
			n++;
		end
		chk({23'h0, a2}, 24'h1);
		host.i2c_read(8'hef, a1, rx);
		chk(rx, 24'h3c5a0f);
	endtask
	// mode 3 leaves the queued word unread; it must survive into I2C
	task automatic t_fifo();
		host.set_mode(1'b0, 1'b1, 1'b1);
		host.spi_frame(1'b1, 1'b1, 8'hac, 1'b0, rx);
		host.set_mode(1'b1, 1'b0, 1'b1);
		host.i2c_read(8'hef, a1, rx);
		chk({23'h0, a1}, 24'h1);
		chk(rx, {exp_word(6), 8'hff});
		host.i2c_read(8'hef, a1, rx);
		chk(rx, 24'hffffff);
		chk({23'h0, sda_out}, 24'h0);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		adc_value = 24'h8f1b94;
		run_d = 1'b0;
		busy_cnt = 0;
		cyc = 0;
		num_errors = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_conv_spi();
		t_prom(1'b0);
		t_prom(1'b1);
		t_i2c();
		t_fifo();
		print_verdict();
	end
endmodule
`default_nettype wire
